/* File: rtl/tks_pkg.sv */
// Package for the two-wire touchkey slave port and its bus master.
// Assumes both ends are joined through tks_if.
`default_nettype none
package tks_pkg;
  localparam logic [6:0] TKS_ADDR_BASE = 7'h58;
  localparam logic [6:0] TKS_GCALL_ADDR = 7'h00;
  localparam logic [1:0] TKS_10B_PREFIX = 2'h3;
  localparam logic [4:0] TKS_10B_MARK = 5'h1E;
  localparam int TKS_SYS_NS = 10;
  localparam int TKS_SCL_STD_NS = 10000;
  localparam int TKS_SCL_FAST_NS = 2500;
  localparam int TKS_QTR_FAST = TKS_SCL_FAST_NS / (4 * TKS_SYS_NS);
  localparam int TKS_QTR_STD = TKS_SCL_STD_NS / (4 * TKS_SYS_NS);
  localparam logic [7:0] TKS_NOINC_LO = 8'h80;
  localparam logic [7:0] TKS_NOINC_HI = 8'h8F;
  localparam logic [7:0] TKS_PTR_RST = 8'h00;
endpackage : tks_pkg
`default_nettype wire

/* File: rtl/tks_if.sv */
// Two-wire bus between the master end and the slave port.
// Open-drain: a line is low when any party enables its driver with its output low.
`default_nettype none
interface tks_if;
  logic scl_o, scl_oe;
  logic sda_m_o, sda_m_oe;
  logic sda_s_o, sda_s_oe;
  logic scl_line, serial_data_pin;
  assign scl_line = ~(scl_oe & ~scl_o);
  assign serial_data_pin = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe,
    input scl_line, serial_data_pin);
  modport slave (output sda_s_o, sda_s_oe,
    input scl_line, serial_data_pin);
endinterface : tks_if
`default_nettype wire

/* File: rtl/tks_slave.sv */
// Slave port: start/stop detection, address match, byte transfer.
// Assumes the link clock is the master's serial clock line itself;
// register writes cross to clk_sys by toggle handshakes; reads take rd_ptr and rd_data directly.
//
// Notes on behaviour
// R1: Address 0x58 plus two select pins
// R2: Select pins sampled once after reset
// R3: Start is data falling, clock high
// R4: Ignore bus until start seen
// R5: Stop is data rising, clock high
// R6: Stop after nack returns to idle
// R7: Stop ends register write
// R8: Receiver pulls data low in ninth bit
// R9: Data left high means not acknowledged
// R10: Data sampled on rising clock edge
// R11: Direction bit one reads, zero writes
// R12: Acknowledge own address, else stay off
// R13: Read: index write, restart, read, stop
// R14: Reads continue, pointer auto-increments
// R15: Writes continue, pointer auto-increments
// R16: Non-incrementing range keeps pointer fixed
// R17: Standard and fast rates supported
// R18: Seven and ten bit addressing; ten-bit frames ignore the direction bit and are taken as writes
// R19: General call recognised
// R20: No clock stretching
`default_nettype none
module tks_slave
  import tks_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  tks_if.slave bus,
  output logic wr_stb,
  output logic [7:0] wr_ptr,
  output logic [7:0] wr_data,
  output logic gcall_stb,
  output logic [7:0] rd_ptr,
  input wire logic [7:0] rd_data
);
  // ----------------------------------------------------------------
  // Link domain (clocked by the serial clock and data lines)
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR2, ST_INDEX, ST_WDATA,
    ST_RDATA, ST_SKIP} tks_state_t;

  function automatic logic [7:0] tks_next_ptr(input logic [7:0] p);
    tks_next_ptr = (p >= TKS_NOINC_LO && p <= TKS_NOINC_HI) ? p
      : p + 8'h01; // R16
  endfunction : tks_next_ptr

  wire logic scl = bus.scl_line;
  wire logic sda = bus.serial_data_pin;
  logic [6:0] own_q;
  logic strap_done_q;
  // Link logic has no reset: it starts from these values at power-up
  logic start_tg_q = 1'b0;
  logic stop_tg_q = 1'b0;
  logic start_cl_q = 1'b0;
  logic stop_cl_q = 1'b0;
  // Start/stop are edges of data while clock high: data is the clock
  always_ff @(negedge sda) begin
    if (scl) start_tg_q <= ~start_tg_q; // R3
  end
  always_ff @(posedge sda) begin
    if (scl) stop_tg_q <= ~stop_tg_q; // R5
  end

  tks_state_t st_q = ST_IDLE;
  logic [3:0] bit_q = 4'h0;
  logic [7:0] sh_q = 8'h00;
  logic [7:0] ptr_q = TKS_PTR_RST;
  logic [7:0] tx_q = 8'h00;
  logic rw_q = 1'b0;
  logic gc_q = 1'b0;
  logic ack_phase_q = 1'b0;
  logic drive_q = 1'b0;
  logic drv_bit_q = 1'b1;
  logic ten_q = 1'b0;
  logic rd_ack_q = 1'b0;
  logic wr_tg_q = 1'b0;
  logic [7:0] wr_ptr_l, wr_dat_l;
  logic gc_tg_q = 1'b0;
  wire logic new_start = start_tg_q != start_cl_q;
  wire logic new_stop = stop_tg_q != stop_cl_q;
  wire logic [7:0] byte_in = {sh_q[6:0], sda};
  wire logic addr_hit = byte_in[7:1] == own_q; // R1 R12
  wire logic gc_hit = byte_in[7:1] == TKS_GCALL_ADDR && !byte_in[0]; // R19
  wire logic ten_hit = byte_in[7:3] == TKS_10B_MARK &&
    byte_in[2:1] == TKS_10B_PREFIX; // R18

  // Sample on rising clock edge
  always_ff @(posedge scl) begin // R10
    start_cl_q <= start_tg_q;
    stop_cl_q <= stop_tg_q;
    if (new_start) begin // R4
      st_q <= ST_ADDR;
      bit_q <= 4'h1;
      sh_q <= {7'h00, sda};
      ack_phase_q <= 1'b0;
      rd_ack_q <= 1'b0;
    end else if (new_stop || st_q == ST_IDLE) begin
      st_q <= ST_IDLE; // R6 R7
      ack_phase_q <= 1'b0;
    end else if (ack_phase_q) begin
      ack_phase_q <= 1'b0;
      rd_ack_q <= 1'b0;
      bit_q <= 4'h0;
      // Master nack ends read data until stop or restart
      if (st_q == ST_RDATA && sda) st_q <= ST_SKIP; // R9
    end else begin
      sh_q <= byte_in;
      bit_q <= bit_q + 4'h1;
      if (bit_q == 4'h7) begin
        ack_phase_q <= 1'b1;
        case (st_q)
          ST_ADDR: begin
            if (ten_hit) begin
              ten_q <= 1'b1;
              st_q <= ST_ADDR2;
            end else if (addr_hit) begin
              rw_q <= byte_in[0]; // R11
              rd_ack_q <= byte_in[0]; // R12
              st_q <= byte_in[0] ? ST_RDATA : ST_INDEX; // R13
              gc_q <= 1'b0;
            end else if (gc_hit) begin
              gc_q <= 1'b1;
              st_q <= ST_WDATA;
            end else st_q <= ST_SKIP; // R12
          end
          ST_ADDR2: st_q <= byte_in == {1'b0, own_q} ? ST_INDEX : ST_SKIP;
          ST_INDEX: begin
            ptr_q <= byte_in;
            st_q <= ST_WDATA;
          end
          ST_WDATA: begin
            wr_ptr_l <= ptr_q;
            wr_dat_l <= byte_in;
            if (gc_q) gc_tg_q <= ~gc_tg_q; // R19
            else begin
              wr_tg_q <= ~wr_tg_q;
              ptr_q <= tks_next_ptr(ptr_q); // R15
            end
          end
          ST_RDATA: ptr_q <= tks_next_ptr(ptr_q); // R14
          default: st_q <= ST_SKIP;
        endcase
      end
    end
  end

  // Drive on falling edge: ack or read bit, never stretch clock
  // A read address is acked by us; read data is acked by the master
  wire logic ack_due = ack_phase_q && (rd_ack_q || (st_q != ST_SKIP &&
    st_q != ST_RDATA && st_q != ST_IDLE));
  always_ff @(negedge scl) begin // R20
    if (new_stop || st_q == ST_IDLE) begin
      drive_q <= 1'b0;
    end else if (ack_due) begin
      drive_q <= 1'b1; // R8
      drv_bit_q <= 1'b0;
    end else if (st_q == ST_RDATA && !ack_phase_q) begin
      if (bit_q == 4'h0) tx_q <= rd_data;
      drive_q <= 1'b1;
      drv_bit_q <= bit_q == 4'h0 ? rd_data[7] : tx_q[3'h7 - bit_q[2:0]];
    end else if (ack_phase_q && st_q == ST_RDATA) begin
      drive_q <= 1'b0; // R8
    end else begin
      drive_q <= 1'b0;
    end
  end
  assign bus.sda_s_o = drv_bit_q;
  assign bus.sda_s_oe = drive_q & ~drv_bit_q;
  assign rd_ptr = ptr_q;

  // ----------------------------------------------------------------
  // System domain: strap capture and write crossing
  // ----------------------------------------------------------------
  logic [2:0] wr_sync_q, gc_sync_q;
  logic [1:0] sel_meta_q, sel_sync_q;
  logic [7:0] wr_ptr_q, wr_data_q;
  logic wr_stb_q, gc_stb_q;
  wire logic wr_new = wr_sync_q[2] != wr_sync_q[1];
  wire logic gc_new = gc_sync_q[2] != gc_sync_q[1];
  // Straps are pins: two flops before capture, filled during reset
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      sel_meta_q <= {addr_select_hi, addr_select_lo};
      sel_sync_q <= sel_meta_q;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_done_q <= 1'b0;
      own_q <= TKS_ADDR_BASE;
      wr_sync_q <= 3'h0;
      gc_sync_q <= 3'h0;
      wr_ptr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_stb_q <= 1'b0;
      gc_stb_q <= 1'b0;
    end else if (clk_en) begin
      if (!strap_done_q) begin // R2
        strap_done_q <= 1'b1;
        own_q <= TKS_ADDR_BASE | {5'h00, sel_sync_q}; // R1
      end
      wr_sync_q <= {wr_sync_q[1:0], wr_tg_q};
      gc_sync_q <= {gc_sync_q[1:0], gc_tg_q};
      wr_stb_q <= wr_new;
      gc_stb_q <= gc_new;
      // Latches are steady long before the toggle is seen here
      if (wr_new || gc_new) begin
        wr_ptr_q <= wr_ptr_l;
        wr_data_q <= wr_dat_l;
      end
    end
  end
  assign wr_stb = clk_en & wr_stb_q; // R7
  assign gcall_stb = clk_en & gc_stb_q; // R19
  assign wr_ptr = wr_ptr_q;
  assign wr_data = wr_data_q;
endmodule : tks_slave
`default_nettype wire

/* File: rtl/tks_master.sv */
// Bus master end: one transaction per command, clock from a divider.
// Assumes the slave never stretches the clock.
`default_nettype none
module tks_master
  import tks_pkg::*;
#(
  parameter int QTR = TKS_QTR_FAST
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  tks_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_index,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  // ----------------------------------------------------------------
  // Sequencer: start, bytes, restart, stop
  // ----------------------------------------------------------------
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} tks_mst_t;
  tks_mst_t st_q;
  logic [15:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q, rd_q;
  logic scl_q, sda_q, nack_q, rd_q_cmd, rsp_q;
  logic [1:0] sda_s_q;
  wire logic tick = div_q == 16'(QTR - 1);
  wire logic [2:0] last_byte = rd_q_cmd ? 3'h3 : 3'h2;
  function automatic logic [7:0] tks_byte(input logic [2:0] n,
      input logic [6:0] a, input logic rd, input logic [7:0] ix,
      input logic [7:0] wd);
    case (n)
      3'h0: tks_byte = {a, 1'b0};
      3'h1: tks_byte = ix;
      3'h2: tks_byte = rd ? {a, 1'b1} : wd;
      default: tks_byte = 8'hFF;
    endcase
  endfunction : tks_byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= M_IDLE;
      div_q <= 16'h0000;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
      rd_q_cmd <= 1'b0;
      rsp_q <= 1'b0;
      sda_s_q <= 2'h3;
    end else if (clk_en) begin
      sda_s_q <= {sda_s_q[0], bus.serial_data_pin};
      rsp_q <= 1'b0;
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      case (st_q)
        M_IDLE: if (cmd_valid) begin
          st_q <= M_START;
          rd_q_cmd <= cmd_read;
          byte_q <= 3'h0;
          ph_q <= 2'h0;
          nack_q <= 1'b0;
          sda_q <= 1'b1;
        end
        M_START: if (tick) begin // R3 R13
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
          end else if (ph_q == 2'h1) sda_q <= 1'b0;
          else if (ph_q == 2'h2) begin
            scl_q <= 1'b0;
            st_q <= M_BIT;
            bit_q <= 4'h0;
            ph_q <= 2'h0;
            sh_q <= tks_byte(byte_q, cmd_addr, rd_q_cmd, cmd_index,
              cmd_wdata);
          end
        end
        M_BIT: if (tick) begin // R10
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            // Ninth bit released: slave acks, or our nack on read data
            sda_q <= bit_q == 4'h8 ? 1'b1 : sh_q[7]; // R8 R9
          end else if (ph_q == 2'h1) scl_q <= 1'b1;
          else if (ph_q == 2'h2) begin
            if (bit_q == 4'h8 && byte_q != 3'h3 && sda_s_q[1])
              nack_q <= 1'b1;
            if (byte_q == 3'h3 && bit_q != 4'h8)
              rd_q <= {rd_q[6:0], sda_s_q[1]};
          end else begin
            scl_q <= 1'b0;
            sh_q <= {sh_q[6:0], 1'b1};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              byte_q <= byte_q + 3'h1;
              sh_q <= tks_byte(byte_q + 3'h1, cmd_addr, rd_q_cmd,
                cmd_index, cmd_wdata);
              if (byte_q == last_byte || nack_q) st_q <= M_STOP;
              else if (rd_q_cmd && byte_q == 3'h1) begin
                st_q <= M_START; // restart
                ph_q <= 2'h0;
              end
            end
          end
        end
        M_STOP: if (tick) begin // R5 R6
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) sda_q <= 1'b0;
          else if (ph_q == 2'h1) scl_q <= 1'b1;
          else if (ph_q == 2'h2) sda_q <= 1'b1;
          else begin
            st_q <= M_IDLE;
            rsp_q <= 1'b1;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
  // Data bits of a slave-transmitted byte are released for sda read
  wire logic rx_bit = byte_q == 3'h3 && bit_q != 4'h8 && st_q == M_BIT;
  assign bus.scl_o = scl_q;
  assign bus.scl_oe = ~scl_q;
  assign bus.sda_m_o = sda_q;
  assign bus.sda_m_oe = ~sda_q & ~rx_bit;
  assign cmd_ready = st_q == M_IDLE;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rd_q;
  assign rsp_nack = nack_q;
endmodule : tks_master
`default_nettype wire

/* File: test/tks_link_properties.sv */
// Checker for the two-wire link between the master end and slave port.
// Sees the resolved lines and the slave's drive; own_addr is the strap.
`default_nettype none
module tks_link_chk
  import tks_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [6:0] own_addr,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl_line,
  input wire logic serial_data_pin
);
  // ------
  // Frame tracking
  // ------
  logic scl_p_q, sda_p_q, frm_q, rd_q, off_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  wire slv_low = sda_s_oe & ~sda_s_o;
  wire rise = scl_line & ~scl_p_q;
  wire start_ev = scl_line & scl_p_q & sda_p_q & ~serial_data_pin;
  wire stop_ev = scl_line & scl_p_q & ~sda_p_q & serial_data_pin;
  wire own = sh_q[7:1] == own_addr || sh_q[7:1] == TKS_GCALL_ADDR;
  wire ninth = rise && frm_q && bit_q == 4'h8;
  always_ff @(posedge clk_sys) begin
    scl_p_q <= scl_line;
    sda_p_q <= serial_data_pin;
    if (rst || start_ev) begin
      frm_q <= ~rst;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
      off_q <= 1'b0;
    end else if (stop_ev) begin
      frm_q <= 1'b0;
    end else if (rise && frm_q) begin
      sh_q <= {sh_q[6:0], serial_data_pin};
      bit_q <= ninth ? 4'h0 : bit_q + 4'h1;
      if (ninth && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
      if (bit_q == 4'h7 && byte_q == 2'h0) rd_q <= serial_data_pin;
      if (ninth && byte_q == 2'h0) off_q <= ~own;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_quiet_idle: assert property (
    !frm_q |-> !slv_low) else $error("slave drives outside frame");
  chk_addr_ack: assert property (
    ninth && byte_q == 2'h0 |-> slv_low == own) else $error("address ack");
  chk_addr_silent: assert property (
    rise && frm_q && bit_q < 4'h8 && !rd_q |-> !slv_low)
    else $error("slave drives master bits");
  chk_data_ack: assert property (
    ninth && byte_q != 2'h0 && !rd_q && !off_q |-> slv_low)
    else $error("write byte not acked");
  chk_read_release: assert property (
    ninth && byte_q != 2'h0 && rd_q |-> !slv_low)
    else $error("slave holds master ack bit");
  chk_stay_off: assert property (
    off_q |-> !slv_low) else $error("deselected slave drives");
  chk_edge_low: assert property (
    !$stable(slv_low) |-> !scl_line) else $error("slave edge with clock high");
  chk_stop_free: assert property (
    stop_ev |=> serial_data_pin && scl_line) else $error("lines held after stop");
endmodule : tks_link_chk
`default_nettype wire

/* File: test/touchkey_i2c_slave_port_test.sv */
// Bench: master end and slave port face each other across tks_if.
// A register array behind the slave answers reads; no clock stretch.
`default_nettype none
module touchkey_i2c_slave_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tks_pkg::*;
  typedef struct packed {
    logic rd; logic [6:0] a; logic [7:0] ix, wd; logic nk; logic [7:0] rv;
  } tks_row_t;
  // Straps move to 01 after reset; 0x5A must stay the address
  localparam tks_row_t ROWS [9] = '{
    '{1'b0, 7'h5A, 8'h10, 8'h3C, 1'b0, 8'h00},
    '{1'b1, 7'h5A, 8'h10, 8'h00, 1'b0, 8'h3C},
    '{1'b0, 7'h59, 8'h11, 8'h77, 1'b1, 8'h00},
    '{1'b1, 7'h5A, 8'h11, 8'h00, 1'b0, 8'hB4},
    '{1'b1, 7'h58, 8'h00, 8'h00, 1'b1, 8'h00},
    '{1'b0, 7'h5A, 8'h8F, 8'hC3, 1'b0, 8'h00},
    '{1'b1, 7'h5A, 8'h8F, 8'h00, 1'b0, 8'hC3},
    '{1'b1, 7'h5A, 8'hFF, 8'h00, 1'b0, 8'h5A},
    '{1'b0, 7'h5B, 8'hFF, 8'h01, 1'b1, 8'h00}};
  logic clk_sys = 1'b0, rst = 1'b1, sel_hi = 1'b1, sel_lo = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00, own = 7'h5A;
  logic [7:0] cmd_index = 8'h00, cmd_wdata = 8'h00, rd_data;
  logic cmd_ready, rsp_valid, rsp_nack, wr_stb, gcall_stb;
  logic [7:0] rsp_rdata, wr_ptr, wr_data, rd_ptr;
  logic [7:0] mem [256];
  int fail_count = 0, checks_done = 0, wr_cnt = 0, gc_cnt = 0;
  tks_if i_tks_if ();
  tks_master #(.QTR(4)) i_tks_master (.clk_sys(clk_sys), .rst(rst),
    .clk_en(1'b1), .bus(i_tks_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  tks_slave i_tks_slave (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
    .addr_select_hi(sel_hi), .addr_select_lo(sel_lo), .bus(i_tks_if),
    .wr_stb(wr_stb), .wr_ptr(wr_ptr), .wr_data(wr_data),
    .gcall_stb(gcall_stb), .rd_ptr(rd_ptr), .rd_data(rd_data));
  tks_link_chk i_tks_link_chk (.clk_sys(clk_sys), .rst(rst),
    .own_addr(own), .sda_s_o(i_tks_if.sda_s_o),
    .sda_s_oe(i_tks_if.sda_s_oe), .scl_line(i_tks_if.scl_line),
    .serial_data_pin(i_tks_if.serial_data_pin));
  assign rd_data = mem[rd_ptr];
  always @(posedge clk_sys) begin
    if (wr_stb) mem[wr_ptr] <= wr_data;
    if (wr_stb) wr_cnt <= wr_cnt + 1;
    if (gcall_stb) gc_cnt <= gc_cnt + 1;
  end
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ------
  // Tasks
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Called at a falling edge; fields stand until the next command
  task automatic run(input logic rd, input logic [6:0] a,
      input logic [7:0] ix, input logic [7:0] wd);
    int n;
    cmd_read = rd;
    cmd_addr = a;
    cmd_index = ix;
    cmd_wdata = wd;
    for (n = 0; cmd_ready !== 1'b1 && n < 100; n++) @(negedge clk_sys);
    if (cmd_ready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 3000; n++) @(negedge clk_sys);
    if (n >= 3000 && rsp_valid !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
  endtask : run
  // ------
  // Sequence
  // ------
  initial begin
    int n0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    sel_hi = 1'b0;
    sel_lo = 1'b1;
    check({6'h0, i_tks_if.scl_line, i_tks_if.serial_data_pin}, 8'h03);
    foreach (ROWS[i]) begin
      n0 = wr_cnt;
      run(ROWS[i].rd, ROWS[i].a, ROWS[i].ix, ROWS[i].wd);
      check({7'h0, rsp_nack}, {7'h0, ROWS[i].nk});
      if (ROWS[i].rd && !ROWS[i].nk) check(rsp_rdata, ROWS[i].rv);
      if (ROWS[i].rd && !ROWS[i].nk && ROWS[i].ix >= TKS_NOINC_LO &&
          ROWS[i].ix <= TKS_NOINC_HI) check(rd_ptr, ROWS[i].ix);
      if (ROWS[i].rd && !ROWS[i].nk && (ROWS[i].ix < TKS_NOINC_LO ||
          ROWS[i].ix > TKS_NOINC_HI)) check(rd_ptr, ROWS[i].ix + 8'h01);
      if (!ROWS[i].rd) check(8'(wr_cnt - n0), {7'h0, !ROWS[i].nk});
      if (!ROWS[i].rd && !ROWS[i].nk) check(wr_ptr, ROWS[i].ix);
      if (!ROWS[i].rd && !ROWS[i].nk) check(wr_data, ROWS[i].wd);
    end
    run(1'b0, TKS_GCALL_ADDR, 8'h55, 8'h66);
    check({7'h0, rsp_nack}, 8'h00);
    check({7'h0, gc_cnt > 0}, 8'h01);
    // Every strap code, with the pins moved away once sampled
    for (int k = 0; k < 4; k++) begin
      {sel_hi, sel_lo} = 2'(k);
      own = TKS_ADDR_BASE + 7'(k);
      rst = 1'b1;
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      {sel_hi, sel_lo} = ~2'(k);
      run(1'b0, own, 8'h20, 8'(k));
      check({7'h0, rsp_nack}, 8'h00);
      run(1'b1, own, 8'h20, 8'h00);
      check(rsp_rdata, 8'(k));
    end
    report_and_stop();
  end
endmodule : touchkey_i2c_slave_port_test
`default_nettype wire
